//--- hw/phase_shed_ramp_config_reg.sv
// paged phase shedding and ramp configuration register with its controllers
// ------------------------------------------------------------------
// Notes on behaviour
// R1: word reads and writes only, bytes refused
// R2: page 00h reaches the first channel copy
// R3: page 01h reaches the second channel copy
// R4: bits 15:14 trim six-to-five drop, page zero
// R5: bits 13:12 trim five-to-four drop, page zero
// R6: bits 11:10 trim four-to-three drop, page zero
// R7: bits 9:8 trim three-to-two drop, both pages
// R8: average current compared against peak-efficiency based threshold
// R9: bit 7 enables phase shedding
// R10: bits 6:5 set undershoot ramp amplitude
// R11: bit 4 forces 120 mV with two phases
// R12: bit 3 forces 80 mV with one phase
// R13: bits 2:0 base ramp, 40 mV steps
// R14: shedding off runs all available phases
// R15: drop after 85 us below; add immediately
// R16: add ascending, drop descending phase numbers
// R17: both copies loaded from nonvolatile store first
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "phase_shed_regs.svh"
module phase_shed_ramp_config_reg
  import phase_shed_pkg::*;
#(
  parameter int PHASES_A = 6,
  parameter int PHASES_B = 2,
  parameter int CUR_W = 10,
  parameter int DROP_CYCLES = `DROP_DELAY_NS * `CLK_MHZ / 1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management bus command port
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] page,
  input wire logic wrWord,
  input wire logic rdWord,
  input wire logic byteAccess,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData_r,
  output logic rdValid_r,
  output logic accessRefused_r,
  // nonvolatile defaults
  input wire logic nvmLoad,
  input wire logic [15:0] nvmWordA,
  input wire logic [15:0] nvmWordB,
  // first channel
  input wire logic [CUR_W-1:0] peakEffCurrentA,
  input wire logic [CUR_W-1:0] avgCurrentA,
  input wire logic peakOverAddA,
  input wire logic [1:0] dropTrimTwoToOneA,
  input wire logic undershootLevel1A,
  output logic [PHASES_A-1:0] phaseEnableA_r,
  output logic [8:0] rampMvA_r,
  // second channel
  input wire logic [CUR_W-1:0] peakEffCurrentB,
  input wire logic [CUR_W-1:0] avgCurrentB,
  input wire logic peakOverAddB,
  input wire logic [1:0] dropTrimTwoToOneB,
  input wire logic undershootLevel1B,
  output logic [PHASES_B-1:0] phaseEnableB_r,
  output logic [8:0] rampMvB_r
);
  logic [1:0] rstSync_r;
  logic rstSync_n;
  logic [15:0] wordA_r;
  logic [15:0] wordB_r;
  logic loaded_r;
  logic hit;
  logic pageA;
  logic pageB;
  logic [15:0] wrMasked;
  logic wrHit;
  logic rdHit;
  logic pageOk;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // a word strobe aimed at this register; byte and block forms never
  // qualify, so a short transfer cannot leave half a word behind
  function automatic logic wordStrobe(input logic [7:0] code,
      input logic strobe, input logic isByte);
    wordStrobe = code == `CFG_CMD_CODE && strobe && !isByte;
  endfunction

  // only the two channel pages are backed by storage
  function automatic logic pageBacked(input logic [7:0] pg);
    pageBacked = pg == `CFG_PAGE_A || pg == `CFG_PAGE_B;
  endfunction

  // bits that a page copy really holds; the rest read back as zero
  function automatic logic [15:0] pageMask(input logic [7:0] pg);
    if (pg == `CFG_PAGE_A) pageMask = 16'hFFFF;
    else pageMask = ~`CFG_PAGE0_ONLY_MASK;
  endfunction

  // a strobe that the register turns away
  function automatic logic refusedAccess(input logic isWrite,
      input logic isByte, input logic known, input logic ready);
    refusedAccess = isByte || !known || (isWrite && !ready);
  endfunction

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstSync_n = rstSync_r[1];

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  assign hit = cmdCode == `CFG_CMD_CODE;
  assign pageA = page == `CFG_PAGE_A; // R2
  assign pageB = page == `CFG_PAGE_B; // R3
  assign pageOk = pageBacked(page); // R2 R3
  assign wrHit = wordStrobe(cmdCode, wrWord, byteAccess); // R1
  assign rdHit = wordStrobe(cmdCode, rdWord, byteAccess); // R1
  // second copy has no storage for the upper trims
  assign wrMasked = wrData & pageMask(page); // R4 R5 R6

  // ------------------------------------------------------------------
  // storage: nvm load wins over a bus write in the same cycle
  // ------------------------------------------------------------------
  // writes wait for the stored defaults, so a host cannot race the load
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) wordA_r <= `CFG_RESET_WORD;
    else if (nvmLoad) wordA_r <= nvmWordA; // R17
    else if (loaded_r && wrHit && pageA) wordA_r <= wrData; // R1 R2
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) wordB_r <= `CFG_RESET_WORD;
    else if (nvmLoad) wordB_r <= nvmWordB & pageMask(`CFG_PAGE_B); // R17
    else if (loaded_r && wrHit && pageB) wordB_r <= wrMasked; // R3 R7
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) loaded_r <= 1'b0;
    else if (nvmLoad) loaded_r <= 1'b1; // R17
  end

  // ------------------------------------------------------------------
  // read answer and refusal flag
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) rdValid_r <= 1'b0;
    else rdValid_r <= rdHit && pageOk; // R1
  end

  // read data holds until the next read of this register; a read of an
  // unbacked page answers nothing and clears the data word
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) rdData_r <= 16'h0000;
    else if (rdHit && pageA) rdData_r <= wordA_r; // R2
    else if (rdHit && pageB) rdData_r <= wordB_r; // R3
    else if (rdHit) rdData_r <= 16'h0000;
  end

  // refused: byte access, an unsupported page, or a write before load;
  // the flag is a one-cycle pulse, so the host must sample it at once
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) accessRefused_r <= 1'b0;
    else accessRefused_r <= hit && (wrWord || rdWord)
        && refusedAccess(wrWord, byteAccess, pageOk, loaded_r); // R1
  end

  // ------------------------------------------------------------------
  // channel controllers
  // ------------------------------------------------------------------
  // both copies share one load flag: neither channel decides on the
  // reset word while the other already runs on stored defaults
  cfg_page_if cfgA ();
  cfg_page_if cfgB ();
  assign cfgA.cfg = cfg_word_t'(wordA_r);
  assign cfgA.loaded = loaded_r;
  assign cfgB.cfg = cfg_word_t'(wordB_r);
  assign cfgB.loaded = loaded_r;

  phase_shed_ctrl #(
    .MAX_PHASES(PHASES_A),
    .CUR_W(CUR_W),
    .DROP_CYCLES(DROP_CYCLES)
  ) ctrlA (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .page(cfgA),
    .peakEffCurrent(peakEffCurrentA),
    .avgCurrent(avgCurrentA),
    .peakOverAdd(peakOverAddA),
    .dropTrimTwoToOne(dropTrimTwoToOneA),
    .undershootLevel1(undershootLevel1A),
    .phaseEnable_r(phaseEnableA_r),
    .rampMv_r(rampMvA_r)
  );

  phase_shed_ctrl #(
    .MAX_PHASES(PHASES_B),
    .CUR_W(CUR_W),
    .DROP_CYCLES(DROP_CYCLES)
  ) ctrlB (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .page(cfgB),
    .peakEffCurrent(peakEffCurrentB),
    .avgCurrent(avgCurrentB),
    .peakOverAdd(peakOverAddB),
    .dropTrimTwoToOne(dropTrimTwoToOneB),
    .undershootLevel1(undershootLevel1B),
    .phaseEnable_r(phaseEnableB_r),
    .rampMv_r(rampMvB_r)
  );
endmodule
`default_nettype wire

//--- hw/phase_shed_regs.svh
// offsets, field positions, reset values and timing counts
`ifndef PHASE_SHED_REGS_SVH
`define PHASE_SHED_REGS_SVH
`define CFG_CMD_CODE 8'hDE
`define CFG_PAGE_A 8'h00
`define CFG_PAGE_B 8'h01
`define CFG_RESET_WORD 16'h0000
// bits that exist on the first page only
`define CFG_PAGE0_ONLY_MASK 16'hFC00
`define FLD_TRIM65_LSB 14
`define FLD_TRIM54_LSB 12
`define FLD_TRIM43_LSB 10
`define FLD_TRIM32_LSB 8
`define FLD_SHED_EN 7
`define FLD_USR_RAMP_LSB 5
`define FLD_TWO_PH_RAMP 4
`define FLD_ONE_PH_RAMP 3
`define FLD_RAMP_LSB 0
`define RAMP_STEP_MV 40
`define RAMP_TWO_PH_MV 120
`define RAMP_ONE_PH_MV 80
`define TRIM_STEP_A 2
`define TRIM_BASE_A 2
`define CLK_MHZ 250
`define DROP_DELAY_NS 85000
`endif

//--- hw/phase_shed_pkg.sv
// types shared by the configuration register and the phase controllers
package phase_shed_pkg;
  typedef struct packed {
    logic [1:0] dropTrimSixToFive;
    logic [1:0] dropTrimFiveToFour;
    logic [1:0] dropTrimFourToThree;
    logic [1:0] dropTrimThreeToTwo;
    logic sheddingEnable;
    logic [1:0] undershootRampOverride;
    logic twoPhaseRampOverride;
    logic singlePhaseRampOverride;
    logic [2:0] baseRamp;
  } cfg_word_t;
endpackage

//--- hw/cfg_page_if.sv
// one page copy of the configuration word, passed to a phase controller
`timescale 1ns/1ps
`default_nettype none
interface cfg_page_if;
  import phase_shed_pkg::*;
  cfg_word_t cfg;
  logic loaded;
  modport src (output cfg, output loaded);
  modport snk (input cfg, input loaded);
endinterface
`default_nettype wire

//--- hw/phase_shed_ctrl.sv
// per-channel phase count and ramp amplitude selection
`timescale 1ns/1ps
`default_nettype none
`include "phase_shed_regs.svh"
module phase_shed_ctrl
  import phase_shed_pkg::*;
#(
  parameter int MAX_PHASES = 6,
  parameter int CUR_W = 10,
  parameter int DROP_CYCLES = 21250
) (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rstSync_n,
  // configuration page
  cfg_page_if.snk page,
  // current sense, amperes
  input wire logic [CUR_W-1:0] peakEffCurrent,
  input wire logic [CUR_W-1:0] avgCurrent,
  input wire logic peakOverAdd,
  input wire logic [1:0] dropTrimTwoToOne,
  input wire logic undershootLevel1,
  // results
  output logic [MAX_PHASES-1:0] phaseEnable_r,
  output logic [8:0] rampMv_r
);
  localparam int CNT_W = $clog2(MAX_PHASES + 1);
  localparam int TH_W = CUR_W + 4;
  localparam int TMR_W = $clog2(DROP_CYCLES + 1);

  // threshold = mult * ieff - 2 A + 2 A * trim, floored at zero
  function automatic logic [TH_W-1:0] dropThreshold(
      input logic [2:0] mult, input logic [CUR_W-1:0] ieff,
      input logic [1:0] trim);
    logic [TH_W+1:0] sum;
    sum = (TH_W+2)'(mult) * (TH_W+2)'(ieff)
        + (TH_W+2)'(trim) * (TH_W+2)'(`TRIM_STEP_A);
    if (sum < (TH_W+2)'(`TRIM_BASE_A)) dropThreshold = '0;
    else dropThreshold = TH_W'(sum - (TH_W+2)'(`TRIM_BASE_A));
  endfunction

  logic [CNT_W-1:0] count_r;
  logic [TMR_W-1:0] dropTmr_r;
  logic [1:0] trimSel;
  logic [TH_W-1:0] thr;
  logic belowDrop;
  logic shedding;

  // the trim for leaving n phases is the field of the n-to-(n-1) step;
  // compared as int so a narrow counter cannot alias an upper step code
  always_comb begin
    unique case (int'(count_r))
      6: trimSel = page.cfg.dropTrimSixToFive; // R4
      5: trimSel = page.cfg.dropTrimFiveToFour; // R5
      4: trimSel = page.cfg.dropTrimFourToThree; // R6
      3: trimSel = page.cfg.dropTrimThreeToTwo; // R7
      default: trimSel = dropTrimTwoToOne;
    endcase
  end

  assign thr = dropThreshold(3'(count_r - CNT_W'(1)), peakEffCurrent,
                             trimSel); // R8
  assign belowDrop = TH_W'(avgCurrent) < thr; // R8
  // no decision until the stored copy has been loaded
  assign shedding = page.loaded && page.cfg.sheddingEnable; // R9 R17

  // ------------------------------------------------------------------
  // phase count
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_r <= CNT_W'(MAX_PHASES);
      dropTmr_r <= '0;
    end else if (!shedding) begin
      count_r <= CNT_W'(MAX_PHASES); // R14
      dropTmr_r <= '0;
    end else if (peakOverAdd) begin
      dropTmr_r <= '0;
      if (count_r < CNT_W'(MAX_PHASES)) count_r <= count_r + CNT_W'(1); // R15
    end else if (count_r > CNT_W'(1) && belowDrop) begin
      if (dropTmr_r >= TMR_W'(DROP_CYCLES - 1)) begin
        count_r <= count_r - CNT_W'(1); // R15
        dropTmr_r <= '0;
      end else begin
        dropTmr_r <= dropTmr_r + TMR_W'(1);
      end
    end else begin
      dropTmr_r <= '0;
    end
  end

  // phases 1..count are on: add upward, shed from the top
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) phaseEnable_r <= '0;
    else if (!page.loaded) phaseEnable_r <= '0;
    else
      for (int i = 0; i < MAX_PHASES; i++)
        phaseEnable_r[i] <= (CNT_W'(i) < count_r); // R16
  end

  // ------------------------------------------------------------------
  // ramp amplitude
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) rampMv_r <= '0;
    else if (!page.loaded) rampMv_r <= '0; // R17
    else if (undershootLevel1 && page.cfg.undershootRampOverride != 2'h0)
      rampMv_r <= 9'(page.cfg.undershootRampOverride) * 9'(`RAMP_STEP_MV); // R10
    else if (count_r == CNT_W'(2) && page.cfg.twoPhaseRampOverride)
      rampMv_r <= 9'(`RAMP_TWO_PH_MV); // R11
    else if (count_r == CNT_W'(1) && page.cfg.singlePhaseRampOverride)
      rampMv_r <= 9'(`RAMP_ONE_PH_MV); // R12
    else
      rampMv_r <= (9'(page.cfg.baseRamp) + 9'h001) * 9'(`RAMP_STEP_MV); // R13
  end
endmodule
`default_nettype wire

//--- testbench/phase_shed_monitor.sv
// concurrent checks on the paged configuration register ports
`timescale 1ns/1ps
`default_nettype none
`include "phase_shed_regs.svh"
module phase_shed_monitor #(
  parameter int PHASES_A = 6,
  parameter int PHASES_B = 2,
  parameter int DROP_CYCLES = 21250
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command port
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] page,
  input wire logic wrWord,
  input wire logic rdWord,
  input wire logic byteAccess,
  input wire logic [15:0] rdData_r,
  input wire logic rdValid_r,
  input wire logic accessRefused_r,
  // results
  input wire logic [PHASES_A-1:0] phaseEnableA_r,
  input wire logic [PHASES_B-1:0] phaseEnableB_r,
  input wire logic [8:0] rampMvA_r
);
  logic hit;
  logic [PHASES_A-1:0] prevA_r;
  logic [15:0] holdCnt_r;
  assign hit = cmdCode == `CFG_CMD_CODE && (wrWord || rdWord);
  // --------
  // phase set age, saturating so long idle spans never wrap
  // --------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevA_r <= '0;
      holdCnt_r <= '0;
    end else begin
      prevA_r <= phaseEnableA_r;
      if (phaseEnableA_r != prevA_r) holdCnt_r <= '0;
      else if (holdCnt_r != 16'hFFFF) holdCnt_r <= holdCnt_r + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  refuse_byte_a: assert property (hit && byteAccess |=>
    accessRefused_r && !rdValid_r) else $error("byte access accepted");
  one_answer_a: assert property (!(rdValid_r && accessRefused_r))
    else $error("read answer and refusal together");
  read_answer_a: assert property (hit && rdWord && !byteAccess &&
    page <= `CFG_PAGE_B |=> rdValid_r && !accessRefused_r)
    else $error("word read not answered");
  bad_page_a: assert property (hit && rdWord && page > `CFG_PAGE_B |=>
    accessRefused_r && !rdValid_r) else $error("bad page not refused");
  page_b_high_a: assert property (rdValid_r &&
    $past(page) == `CFG_PAGE_B |-> rdData_r[15:10] == 6'h00)
    else $error("second page shows first page bits");
  ramp_grid_a: assert property (rampMvA_r <= 9'h140 &&
    rampMvA_r % 9'h028 == 9'h000) else $error("ramp off the grid");
  phase_order_a: assert property ((phaseEnableA_r &
    (phaseEnableA_r + 1'b1)) == '0 &&
    (phaseEnableB_r & (phaseEnableB_r + 1'b1)) == '0)
    else $error("phase set not contiguous");
  drop_delay_a: assert property ($countones(phaseEnableA_r) <
    $countones(prevA_r) |-> holdCnt_r >= DROP_CYCLES - 1)
    else $error("phase dropped too early");
  drop_step_a: assert property ($countones(phaseEnableA_r) <
    $countones(prevA_r) |->
    $countones(phaseEnableA_r) == $countones(prevA_r) - 1)
    else $error("more than one phase dropped");
endmodule
bind phase_shed_ramp_config_reg phase_shed_monitor #(
  .PHASES_A(PHASES_A), .PHASES_B(PHASES_B), .DROP_CYCLES(DROP_CYCLES)
) u_phase_shed_monitor (.clk, .rst_n, .cmdCode, .page, .wrWord, .rdWord,
  .byteAccess, .rdData_r, .rdValid_r, .accessRefused_r, .phaseEnableA_r,
  .phaseEnableB_r, .rampMvA_r);
`default_nettype wire

//--- testbench/pmbus_host.sv
// management bus host issuing word and byte transactions to the register
`timescale 1ns/1ps
`default_nettype none
`include "phase_shed_regs.svh"
module pmbus_host (
  // clock
  input wire logic clk,
  // requests towards the device
  output logic [7:0] cmdCode,
  output logic [7:0] page,
  output logic wrWord,
  output logic rdWord,
  output logic byteAccess,
  output logic [15:0] wrData,
  // answer from the device
  input wire logic [15:0] rdData_r,
  input wire logic rdValid_r,
  input wire logic accessRefused_r
);
  logic [15:0] q;
  logic v;
  logic f;
  initial begin
    cmdCode = 8'h00;
    page = 8'hFF;
    wrWord = 1'b0;
    rdWord = 1'b0;
    byteAccess = 1'b0;
    wrData = 16'h0000;
  end
  // --------
  // one request cycle, answer taken one cycle later
  // --------
  task automatic xfer(input logic w, input logic [7:0] p,
      input logic b, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmdCode = `CFG_CMD_CODE;
    page = p;
    byteAccess = b;
    wrData = d;
    wrWord = w;
    rdWord = !w;
    @(posedge clk);
    #1;
    wrWord = 1'b0;
    rdWord = 1'b0;
    q = rdData_r;
    v = rdValid_r;
    f = accessRefused_r;
    // released command code and write data must not keep the last value
    cmdCode = ~cmdCode;
    wrData = ~wrData;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the paged shedding and ramp register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DROP = 8;
  logic clk;
  logic rst_n = 1'b0;
  logic wrWord, rdWord, byteAccess, rdValid_r, accessRefused_r;
  logic [7:0] cmdCode, page;
  logic [15:0] wrData, rdData_r;
  logic [15:0] nvmWordA = 16'h0000, nvmWordB = 16'hFC05;
  logic nvmLoad = 1'b0, peakOverAddA = 1'b0, usrA = 1'b0;
  logic [9:0] ieffA = 10'h00A, avgA = 10'h02D;
  logic [9:0] ieffB = 10'h005, avgB = 10'h000;
  logic [5:0] phA;
  logic [1:0] phB;
  logic [8:0] rampA, rampB;
  int error_cnt = 0;
  int total_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  pmbus_host u_pmbus_host (.clk, .cmdCode, .page, .wrWord, .rdWord,
    .byteAccess, .wrData, .rdData_r, .rdValid_r, .accessRefused_r);
  phase_shed_ramp_config_reg #(.DROP_CYCLES(DROP))
    u_phase_shed_ramp_config_reg (.clk, .rst_n, .cmdCode, .page, .wrWord,
    .rdWord, .byteAccess, .wrData, .rdData_r, .rdValid_r, .accessRefused_r,
    .nvmLoad, .nvmWordA, .nvmWordB, .peakEffCurrentA(ieffA),
    .avgCurrentA(avgA), .peakOverAddA, .dropTrimTwoToOneA(2'h0),
    .undershootLevel1A(usrA), .phaseEnableA_r(phA), .rampMvA_r(rampA),
    .peakEffCurrentB(ieffB), .avgCurrentB(avgB), .peakOverAddB(1'b0),
    .dropTrimTwoToOneB(2'h1), .undershootLevel1B(1'b0),
    .phaseEnableB_r(phB), .rampMvB_r(rampB));
  // --------
  // shared tasks
  // --------
  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    u_pmbus_host.xfer(1'b1, p, 1'b0, d);
  endtask
  task automatic rd(input logic [7:0] p);
    u_pmbus_host.xfer(1'b0, p, 1'b0, 16'h0000);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    wt(8);
    rst_n = 1'b1;
    wt(3);
    chk("rampA", 16'(rampA), 16'h0000);
    chk("phA", 16'(phA), 16'h0000);
    wr(8'h00, 16'h1234);
    chk("early", 16'(u_pmbus_host.f), 16'h0001);
    nvmLoad = 1'b1;
    wt(1);
    nvmLoad = 1'b0;
    wt(2);
    rd(8'h00);
    chk("nvmA", u_pmbus_host.q, 16'h0000);
    rd(8'h01);
    chk("nvmB", u_pmbus_host.q, 16'h0005);
    chk("phA all", 16'(phA), 16'h003F);
    chk("phB all", 16'(phB), 16'h0003);
    chk("rampB", 16'(rampB), 16'h00F0);
    wr(8'h01, 16'h0015);
    wt(2);
    chk("rampB two", 16'(rampB), 16'h0078);
    $display("defaults test done");
    wr(8'h00, 16'hFF7F);
    wr(8'h01, 16'hFF7F);
    rd(8'h00);
    chk("pageA", u_pmbus_host.q, 16'hFF7F);
    rd(8'h01);
    chk("pageB", u_pmbus_host.q, 16'h037F);
    u_pmbus_host.xfer(1'b1, 8'h00, 1'b1, 16'h0000);
    chk("byte", 16'(u_pmbus_host.f), 16'h0001);
    u_pmbus_host.xfer(1'b1, 8'h02, 1'b0, 16'h0000);
    chk("page2", 16'(u_pmbus_host.f), 16'h0001);
    rd(8'h00);
    chk("kept", u_pmbus_host.q, 16'hFF7F);
    rd(8'hFF);
    chk("pageFF", 16'(u_pmbus_host.v), 16'h0000);
    $display("pages test done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 16'(c));
      wt(2);
      chk("base", 16'(rampA), 16'((c + 1) * 40));
    end
    usrA = 1'b1;
    for (int u = 0; u < 4; u++) begin
      wr(8'h00, 16'(u * 32 + 3));
      wt(2);
      chk("usr", 16'(rampA), u == 0 ? 16'h00A0 : 16'(u * 40));
    end
    usrA = 1'b0;
    $display("ramp test done");
    wr(8'h00, 16'hC080);
    wt(DROP - 2);
    chk("hold", 16'(phA), 16'h003F);
    wt(8);
    chk("drop65", 16'(phA), 16'h001F);
    avgA = 10'h029;
    wr(8'h00, 16'hF080);
    wt(DROP + 6);
    chk("drop54", 16'(phA), 16'h000F);
    peakOverAddA = 1'b1;
    wt(1);
    peakOverAddA = 1'b0;
    wt(1);
    chk("add", 16'(phA), 16'h001F);
    avgA = 10'h021;
    wr(8'h00, 16'hFC80);
    wt(5 * DROP + 10);
    chk("drop43", 16'(phA), 16'h0007);
    wr(8'h00, 16'h3000);
    wt(3);
    chk("shed off", 16'(phA), 16'h003F);
    $display("shed test done");
    wr(8'h01, 16'h0088);
    wt(2);
    chk("rampB 2ph", 16'(rampB), 16'h0028);
    wt(DROP + 6);
    chk("phB one", 16'(phB), 16'h0001);
    chk("rampB 1ph", 16'(rampB), 16'h0050);
    $display("single phase test done");
    test_done;
  end
  initial begin
    wt(3000);
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
